/* exec_pkg.sv */
// constants, register map and carrier types for the accumulator/stack execution block
package exec_pkg;
   localparam int ACC_W = 40;
   localparam int WORD_W = 16;
   localparam int NUM_WREG = 16;
   localparam int PC_W = 23;
   // apb register byte addresses
   localparam logic [7:0] ADDR_INSTR = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_PC = 8'h08;
   localparam logic [7:0] ADDR_ACC1_LO = 8'h0c;
   localparam logic [7:0] ADDR_ACC1_HI = 8'h10;
   localparam logic [7:0] ADDR_ACC2_LO = 8'h14;
   localparam logic [7:0] ADDR_ACC2_HI = 8'h18;
   localparam logic [7:0] ADDR_WREG = 8'h40;
   // status word layout
   localparam int ST_FLAGS_W = 8;
   localparam int ST_ILLEGAL_BIT = 8;
   localparam int ST_BUSY_BIT = 9;
   // opcode fields
   localparam logic [7:0] OP_NEG_ACC = 8'hcb;
   localparam logic [7:0] OP_ACC_EXPONENT_ALIGN_OP_ACC = 8'hce;
   localparam logic [7:0] OP_IDLE = 8'h00;
   localparam logic [7:0] OP_POP_FILE = 8'hf9;
   localparam logic [3:0] OP_IDLE_ALT = 4'hf;
   localparam logic [3:0] OP_POP_WREG = 4'h7;
   localparam logic [2:0] NEG_MID = 3'h1;
   localparam logic [2:0] ACC_EXPONENT_ALIGN_OP_MID = 3'h6;
   localparam logic [6:0] POPW_TAIL = 7'h4f;
   // destination addressing modes
   localparam logic [2:0] AM_DIRECT = 3'h0;
   localparam logic [2:0] AM_IND = 3'h1;
   localparam logic [2:0] AM_POSTDEC = 3'h2;
   localparam logic [2:0] AM_POSTINC = 3'h3;
   localparam logic [2:0] AM_PREDEC = 3'h4;
   localparam logic [2:0] AM_PREINC = 3'h5;
   localparam logic [3:0] SP_IDX = 4'hf;
   localparam logic [15:0] WORD_STEP = 16'h0002;
   localparam logic [22:0] PC_STEP = 23'h000002;
   localparam logic [22:0] PC_RESET = 23'h000000;
   localparam logic [39:0] ACC_RESET = 40'h0000000000;
   localparam logic [39:0] ACC_MOST_NEG = 40'h8000000000;

   typedef struct packed {
      logic z;
      logic n;
      logic either_acc_latched_clip;
      logic either_acc_overflow;
      logic sb;
      logic sa;
      logic ob;
      logic oa;
   } flags_s;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [15:0] wdata;
   } dm_req_s;
endpackage

/* acc_negate_normalize_pop_exec.sv */
// execution unit for accumulator negate/normalize, no-ops and stack pops, apb controlled
//
// Operation
// - negate replaces the chosen accumulator with its two's complement
// - negate works on all 40 bits, never saturates
// - negate touches only overflow and latched-clip flags
// - upper byte zero executes as no-op, rest ignored
// - upper nibble all ones is the alternative no-op, except the pop to file encoding
// - overflowed accumulator shifts right by the fewest bits removing overflow
// - otherwise shift left fewest bits to largest fraction without overflow
// - normalized, zero or all ones: clear dest, set z, clear n
// - signed exponent goes to dest, positive means right shift
// - after normalizing, n follows exponent sign and z clears
// - normalize recomputes target overflow flag, always ending cleared
// - normalize never changes the latched-clip flags
// - normalize encoding holds accumulator bit, mode q and register d
// - pop to file: stack pointer minus 2, then tos to file
// - file target anywhere in the lower 32k words
// - file address field has its lowest bit fixed zero
// - pops move whole words only and keep all flags
// - pop to dest: stack pointer minus 2, then tos to dest
// - pop to dest encoding holds base w, mode h, register d
// - pop to dest is a move from pre-decremented stack pointer
`timescale 1ns/1ns
module acc_negate_normalize_pop_exec (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output exec_pkg::dm_req_s dm_req,
   input wire logic [15:0] dm_rdata
);
   import exec_pkg::*;

   typedef enum logic [1:0] {st_idle, st_exec, st_req, st_load} state_e;

   state_e state_r;
   logic [23:0] ir_r;
   logic [39:0] acc_a_r;
   logic [39:0] acc_b_r;
   logic [22:0] pc_r;
   flags_s flags_r;
   logic illegal_r;
   logic [15:0] wreg_r [NUM_WREG];
   logic busy;
   logic apb_wr;
   logic apb_setup;
   logic instr_go;
   logic mapped;
   logic in_exec;
   logic done;
   logic is_neg;
   logic is_acc_exponent_align_op;
   logic is_nop;
   logic is_idle_op_alt;
   logic is_popf;
   logic is_popw;
   logic is_pop;
   logic [39:0] nacc;
   logic [39:0] neg_res;
   logic [39:0] acc_exponent_align_op_res;
   logic ovf;
   logic can_acc_exponent_align_op;
   logic [3:0] rsh;
   logic [4:0] lsh;
   logic [15:0] exp_val;
   logic signed [39:0] probe;
   logic [3:0] dsel;
   logic [3:0] wsel;
   logic [2:0] amode;
   logic [15:0] base;
   logic [15:0] ea;
   logic [15:0] upd;
   logic dest_mem;
   logic [15:0] sp_dec;
   logic [15:0] file_addr;
   logic [31:0] rd_mux;

   // overflow: guard bits and bit 31 disagree
   function automatic logic ovf40(input logic [39:0] v);
      return ~((&v[39:31]) | ~(|v[39:31]));
   endfunction

   // apb handshake, zero wait states
   assign pready = 1'b1;
   assign apb_setup = psel & ~penable;
   assign apb_wr = psel & penable & pwrite;
   assign busy = (state_r != st_idle);
   assign instr_go = apb_wr & (paddr == ADDR_INSTR) & ~busy;
   assign in_exec = (state_r == st_exec);
   assign mapped = (paddr == ADDR_INSTR) || (paddr == ADDR_STATUS) || (paddr == ADDR_PC) ||
                   (paddr == ADDR_ACC1_LO) || (paddr == ADDR_ACC1_HI) ||
                   (paddr == ADDR_ACC2_LO) || (paddr == ADDR_ACC2_HI) ||
                   (paddr[7:6] == ADDR_WREG[7:6] && paddr[1:0] == 2'b00);
   assign pslverr = psel & penable & ~mapped;

   // decode of the latched instruction word
   assign is_neg = (ir_r[23:16] == OP_NEG_ACC) && (ir_r[14:12] == NEG_MID)
                   && (ir_r[11:0] == 12'h000);
   assign is_acc_exponent_align_op = (ir_r[23:16] == OP_ACC_EXPONENT_ALIGN_OP_ACC) && (ir_r[14:12] == ACC_EXPONENT_ALIGN_OP_MID)
                    && (ir_r[11:7] == 5'h00);
   assign is_nop = (ir_r[23:16] == OP_IDLE);
   assign is_popf = (ir_r[23:16] == OP_POP_FILE) && ~ir_r[0];
   assign is_idle_op_alt = (ir_r[23:20] == OP_IDLE_ALT) && ~is_popf;
   assign is_popw = (ir_r[23:20] == OP_POP_WREG) && ir_r[19] && ~ir_r[14]
                    && (ir_r[6:0] == POPW_TAIL);
   assign is_pop = is_popf | is_popw;
   assign done = (in_exec & ~is_pop) | (state_r == st_load);

   // pre-decremented stack pointer, bit 0 always zero
   assign sp_dec = wreg_r[SP_IDX] - WORD_STEP;
   // file address is the word address field, reaching 64k bytes = 32k words
   assign file_addr = {ir_r[15:1], 1'b0};

   // negate on the full width, wraps instead of saturating
   assign neg_res = ACC_RESET - nacc;

   // normalize shift search
   always_comb begin
      nacc = ir_r[15] ? acc_b_r : acc_a_r;
      ovf = ovf40(nacc);
      rsh = 4'h0;
      lsh = 5'h00;
      probe = '0;
      // fewest right shifts that make the guard bits agree
      for (int s = 8; s >= 1; s--) begin
         probe = $signed(nacc) >>> (31 + s);
         if (probe == '0 || probe == '1) begin
            rsh = 4'(s);
         end
      end
      // fewest left shifts that bring bit 31 apart from bit 30
      for (int s = 30; s >= 1; s--) begin
         probe = $signed(nacc << s);
         if (probe[31] ^ probe[30]) begin
            lsh = 5'(s);
         end
      end
      if (ovf || (nacc[31] ^ nacc[30])) begin
         lsh = 5'h00;
      end
      can_acc_exponent_align_op = ovf || (lsh != 5'h00);
      if (ovf) begin
         exp_val = {12'h000, rsh};
         acc_exponent_align_op_res = 40'($signed(nacc) >>> rsh);
      end else begin
         exp_val = 16'h0000 - {11'h000, lsh};
         acc_exponent_align_op_res = nacc << lsh;
      end
      if (!can_acc_exponent_align_op) begin
         exp_val = 16'h0000;
         acc_exponent_align_op_res = nacc;
      end
   end

   // destination operand fields and effective address
   always_comb begin
      if (is_popw) begin
         dsel = ir_r[10:7];
         amode = ir_r[13:11];
         wsel = ir_r[18:15];
      end else begin
         dsel = ir_r[3:0];
         amode = ir_r[6:4];
         wsel = dsel;
      end
      base = wreg_r[dsel];
      ea = base;
      upd = base;
      dest_mem = 1'b1;
      case (amode)
         AM_DIRECT: dest_mem = 1'b0;
         AM_IND: ea = base;
         AM_POSTDEC: upd = base - WORD_STEP;
         AM_POSTINC: upd = base + WORD_STEP;
         AM_PREDEC: begin
            ea = base - WORD_STEP;
            upd = ea;
         end
         AM_PREINC: begin
            ea = base + WORD_STEP;
            upd = ea;
         end
         default: begin
            // offset mode only on pop, normalize treats it as plain indirect
            ea = is_popw ? base + wreg_r[wsel] : base;
         end
      endcase
   end

   // sequencer: exec, then for pops a read and a load step
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= st_idle;
      end else begin
         case (state_r)
            st_idle: if (instr_go) state_r <= st_exec;
            st_exec: state_r <= is_pop ? st_req : st_idle;
            st_req: state_r <= st_load;
            st_load: state_r <= st_idle;
            default: state_r <= st_idle;
         endcase
      end
   end

   // instruction latch, written only while idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ir_r <= 24'h000000;
      end else if (instr_go) begin
         ir_r <= pwdata[23:0];
      end
   end

   // program counter, one word per instruction
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_r <= PC_RESET;
      end else if (done) begin
         pc_r <= pc_r + PC_STEP;
      end else if (apb_wr && paddr == ADDR_PC && !busy) begin
         pc_r <= pwdata[22:0];
      end
   end

   // unknown encodings are flagged and do nothing except step the pc
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         illegal_r <= 1'b0;
      end else if (in_exec) begin
         illegal_r <= ~(is_neg | is_acc_exponent_align_op | is_nop | is_idle_op_alt | is_pop);
      end
   end

   // accumulators; software writes are ignored while busy to avoid races
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_a_r <= ACC_RESET;
         acc_b_r <= ACC_RESET;
      end else if (in_exec && (is_neg || (is_acc_exponent_align_op && can_acc_exponent_align_op))) begin
         if (ir_r[15]) begin
            acc_b_r <= is_neg ? neg_res : acc_exponent_align_op_res;
         end else begin
            acc_a_r <= is_neg ? neg_res : acc_exponent_align_op_res;
         end
      end else if (apb_wr && !busy) begin
         case (paddr)
            ADDR_ACC1_LO: acc_a_r[31:0] <= pwdata;
            ADDR_ACC1_HI: acc_a_r[39:32] <= pwdata[7:0];
            ADDR_ACC2_LO: acc_b_r[31:0] <= pwdata;
            ADDR_ACC2_HI: acc_b_r[39:32] <= pwdata[7:0];
            default: ;
         endcase
      end
   end

   // status flags; pops and no-ops leave them alone
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_r <= '0;
      end else if (in_exec && is_neg) begin
         // only the overflow and clip family moves
         if (ir_r[15]) begin
            flags_r.ob <= ovf40(neg_res);
            flags_r.sb <= flags_r.sb | (nacc == ACC_MOST_NEG);
            flags_r.either_acc_overflow <= flags_r.oa | ovf40(neg_res);
            flags_r.either_acc_latched_clip <= flags_r.sa | flags_r.sb | (nacc == ACC_MOST_NEG);
         end else begin
            flags_r.oa <= ovf40(neg_res);
            flags_r.sa <= flags_r.sa | (nacc == ACC_MOST_NEG);
            flags_r.either_acc_overflow <= flags_r.ob | ovf40(neg_res);
            flags_r.either_acc_latched_clip <= flags_r.sb | flags_r.sa | (nacc == ACC_MOST_NEG);
         end
      end else if (in_exec && is_acc_exponent_align_op) begin
         // clip flags untouched, overflow follows the new contents
         if (ir_r[15]) begin
            flags_r.ob <= ovf40(acc_exponent_align_op_res);
            flags_r.either_acc_overflow <= flags_r.oa | ovf40(acc_exponent_align_op_res);
         end else begin
            flags_r.oa <= ovf40(acc_exponent_align_op_res);
            flags_r.either_acc_overflow <= flags_r.ob | ovf40(acc_exponent_align_op_res);
         end
         flags_r.z <= ~can_acc_exponent_align_op;
         flags_r.n <= can_acc_exponent_align_op & exp_val[15];
      end else if (apb_wr && paddr == ADDR_STATUS && !busy) begin
         flags_r <= pwdata[ST_FLAGS_W-1:0];
      end
   end

   // working registers; the stack pointer keeps bit 0 at zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NUM_WREG; i++) begin
            wreg_r[i] <= 16'h0000;
         end
      end else if (in_exec && is_pop) begin
         wreg_r[SP_IDX] <= sp_dec;
      end else if (in_exec && is_acc_exponent_align_op) begin
         if (!dest_mem) begin
            wreg_r[dsel] <= (dsel == SP_IDX) ? {exp_val[15:1], 1'b0} : exp_val;
         end else begin
            wreg_r[dsel] <= upd;
         end
      end else if (state_r == st_load && is_popw) begin
         if (!dest_mem) begin
            wreg_r[dsel] <= (dsel == SP_IDX) ? {dm_rdata[15:1], 1'b0} : dm_rdata;
         end else begin
            wreg_r[dsel] <= upd;
         end
      end else if (apb_wr && paddr[7:6] == ADDR_WREG[7:6] && paddr[1:0] == 2'b00 && !busy) begin
         if (paddr[5:2] == SP_IDX) begin
            wreg_r[paddr[5:2]] <= {pwdata[15:1], 1'b0};
         end else begin
            wreg_r[paddr[5:2]] <= pwdata[15:0];
         end
      end
   end

   // data memory requests, one word per access, registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dm_req <= '0;
      end else begin
         dm_req.rd <= 1'b0;
         dm_req.wr <= 1'b0;
         if (in_exec && is_pop) begin
            dm_req.rd <= 1'b1;
            dm_req.addr <= sp_dec;
         end else if (in_exec && is_acc_exponent_align_op && dest_mem) begin
            dm_req.wr <= 1'b1;
            dm_req.addr <= ea;
            dm_req.wdata <= exp_val;
         end else if (state_r == st_load && (is_popf || dest_mem)) begin
            // whole word only, no byte lanes
            dm_req.wr <= 1'b1;
            dm_req.addr <= is_popf ? file_addr : ea;
            dm_req.wdata <= dm_rdata;
         end
      end
   end

   // read data captured in the setup phase
   always_comb begin
      rd_mux = 32'h00000000;
      case (paddr)
         ADDR_INSTR: rd_mux = {8'h00, ir_r};
         ADDR_STATUS: rd_mux = {22'h000000, busy, illegal_r, flags_r};
         ADDR_PC: rd_mux = {9'h000, pc_r};
         ADDR_ACC1_LO: rd_mux = acc_a_r[31:0];
         ADDR_ACC1_HI: rd_mux = {24'h000000, acc_a_r[39:32]};
         ADDR_ACC2_LO: rd_mux = acc_b_r[31:0];
         ADDR_ACC2_HI: rd_mux = {24'h000000, acc_b_r[39:32]};
         default: begin
            // unaligned offsets are unmapped and read zero
            if (paddr[7:6] == ADDR_WREG[7:6] && paddr[1:0] == 2'b00) begin
               rd_mux = {16'h0000, wreg_r[paddr[5:2]]};
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
      end else if (apb_setup && !pwrite) begin
         prdata <= rd_mux;
      end
   end

   // checks
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   neg_one_a: assert property (in_exec && is_neg && !ir_r[15] |=>
      acc_a_r == ACC_RESET - $past(acc_a_r) && $stable(acc_b_r))
      else $error("negate of first accumulator wrong");
   neg_wide_a: assert property (in_exec && is_neg && ir_r[15] |=>
      acc_b_r == ACC_RESET - $past(acc_b_r))
      else $error("negate of second accumulator not full width");
   neg_flags_a: assert property (in_exec && is_neg |=>
      flags_r.z == $past(flags_r.z) && flags_r.n == $past(flags_r.n))
      else $error("negate changed n or z");
   nop_hold_a: assert property (in_exec && (is_nop || is_idle_op_alt) |=>
      $stable(acc_a_r) && $stable(acc_b_r) && $stable(flags_r) && !dm_req.wr && !dm_req.rd)
      else $error("no-op changed state");
   acc_exponent_align_op_stuck_a: assert property (in_exec && is_acc_exponent_align_op && !can_acc_exponent_align_op |=>
      flags_r.z && !flags_r.n && $stable(acc_a_r) && $stable(acc_b_r))
      else $error("unnormalizable case handled wrong");
   acc_exponent_align_op_sign_a: assert property (in_exec && is_acc_exponent_align_op && can_acc_exponent_align_op |=>
      !flags_r.z && flags_r.n == $past(exp_val[15]))
      else $error("normalize sign flags wrong");
   acc_exponent_align_op_ovf_a: assert property (in_exec && is_acc_exponent_align_op |=>
      !(($past(ir_r[15])) ? flags_r.ob : flags_r.oa))
      else $error("normalize left overflow set");
   clip_keep_a: assert property (in_exec && is_acc_exponent_align_op |=>
      $stable(flags_r.sa) && $stable(flags_r.sb))
      else $error("normalize changed clip flags");
   pop_sp_a: assert property (in_exec && is_pop |=>
      wreg_r[SP_IDX] == $past(wreg_r[SP_IDX]) - WORD_STEP && dm_req.rd
      && dm_req.addr == wreg_r[SP_IDX] ##2 dm_req.wr == ($past(is_popf) || $past(dest_mem)))
      else $error("pop stack access wrong");
   pop_flags_a: assert property (in_exec && is_pop |=>
      $stable(flags_r)[*3])
      else $error("pop changed flags");
   pc_step_a: assert property (done |=> pc_r == $past(pc_r) + PC_STEP)
      else $error("pc did not step one word");
endmodule

/* stack_mem_model.sv */
// data memory model holding the software stack for the execution bench
`timescale 1ns/1ns
module stack_mem_model (
   input wire logic pclk,
   input wire exec_pkg::dm_req_s dm_req,
   output logic [15:0] dm_rdata
);
   import exec_pkg::*;
   logic [15:0] mem [0:32767];
   logic [15:0] rd_q = 16'h5a5a;
   // word array indexed by byte address over two; answer one cycle after rd
   // outside that cycle the bus toggles, so a late sample never matches stale data
   always @(posedge pclk) begin
      if (dm_req.rd) begin
         rd_q <= mem[dm_req.addr[15:1]];
      end else begin
         rd_q <= ~rd_q;
      end
      if (dm_req.wr) begin
         mem[dm_req.addr[15:1]] <= dm_req.wdata;
      end
   end
   assign dm_rdata = rd_q;
endmodule

/* test_acc_negate_normalize_pop_exec.sv */
// self-checking bench for the accumulator, no-op and stack pop execution block
`timescale 1ns/1ns
module test_acc_negate_normalize_pop_exec;
   import exec_pkg::*;
   typedef struct {logic [31:0] exp; logic [31:0] mask; logic err;} note_s;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   dm_req_s dm_req;
   logic [15:0] dm_rdata;
   int n_errors = 0;
   int comparisons = 0;
   note_s notes[$];
   note_s nt;
   logic [22:0] pc_exp = PC_RESET;
   logic [31:0] q;
   logic [39:0] v;
   logic [3:0] r;
   logic b;
   logic [39:0] unnorm [3] = '{40'h0, 40'hffffffffff, 40'h0040000000};

   always #4 pclk = ~pclk;

   acc_negate_normalize_pop_exec dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .dm_req(dm_req), .dm_rdata(dm_rdata));
   stack_mem_model mem_i (.pclk(pclk), .dm_req(dm_req), .dm_rdata(dm_rdata));

   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task end_sim;
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // read results appear in the access cycle; oldest note is the expectation
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         if (notes.size() == 0) begin
            check("note queue", 32'h0, 32'h1);
         end else begin
            nt = notes.pop_front();
            check("prdata", prdata & nt.mask, nt.exp & nt.mask);
            check("pslverr", {31'h0, pslverr}, {31'h0, nt.err});
         end
      end
   end

   // one apb transfer; request held until pready is seen high
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
      input logic err = 1'b0);
      notes.push_back('{e, m, err});
      xfer(1'b0, a, 32'h0);
   endtask

   function automatic logic [7:0] wa(input int n);
      return ADDR_WREG + 8'(n * 4);
   endfunction

   function automatic logic ovf(input logic [39:0] x);
      return !((&x[39:31]) || !(|x[39:31]));
   endfunction

   task set_acc(input logic s, input logic [39:0] val);
      wr(s ? ADDR_ACC2_LO : ADDR_ACC1_LO, val[31:0]);
      wr(s ? ADDR_ACC2_HI : ADDR_ACC1_HI, {24'h0, val[39:32]});
   endtask

   task rd_acc(input logic s, input logic [39:0] val);
      rd(s ? ADDR_ACC2_LO : ADDR_ACC1_LO, val[31:0], 32'hffffffff);
      rd(s ? ADDR_ACC2_HI : ADDR_ACC1_HI, {24'h0, val[39:32]}, 32'h000000ff);
   endtask

   // issue one instruction, wait out busy, then confirm the pc stepped one word
   task run(input logic [23:0] ins);
      int k;
      wr(ADDR_INSTR, {8'h0, ins});
      repeat (4) @(posedge pclk);
      k = 0;
      do begin
         rd(ADDR_STATUS, 32'h0, 32'h0);
         k++;
      end while (q[ST_BUSY_BIT] !== 1'b0 && k < 20);
      if (k >= 20) check("busy wait", 32'h1, 32'h0);
      pc_exp = pc_exp + PC_STEP;
      rd(ADDR_PC, {9'h0, pc_exp}, 32'h007fffff);
   endtask

   initial begin
      repeat (20000) @(posedge pclk);
      n_errors++;
      end_sim;
   end

   initial begin
      void'($urandom(82792));
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rd(ADDR_STATUS, 32'h0, 32'h3ff);
      rd(ADDR_PC, 32'h0, 32'h007fffff);
      rd(wa(15), 32'h0, 32'hffff);
      rd(8'h3c, 32'h0, 32'hffffffff, 1'b1);
      // negate: documented operands, most negative value, random values
      set_acc(1'b0, 40'h00329059c8);
      wr(ADDR_STATUS, 32'hc0);
      run(24'hcb1000);
      rd_acc(1'b0, 40'hffcd6fa638);
      rd(ADDR_STATUS, 32'hc0, 32'hd3);
      set_acc(1'b1, 40'hfff23010dc);
      run(24'hcb9000);
      rd_acc(1'b1, 40'h000dcfef24);
      set_acc(1'b0, ACC_MOST_NEG);
      wr(ADDR_STATUS, 32'h0);
      run(24'hcb1000);
      rd_acc(1'b0, ACC_MOST_NEG);
      rd(ADDR_STATUS, 32'h35, 32'h3f);
      for (int i = 0; i < 4; i++) begin
         b = i[0];
         v = 40'({$urandom(), $urandom()});
         set_acc(b, v);
         wr(ADDR_STATUS, 32'h0);
         run({8'hcb, b, 3'h1, 12'h0});
         rd_acc(b, -v);
         rd(ADDR_STATUS, {27'h0, ovf(-v), 2'h0, b & ovf(-v), !b & ovf(-v)}, 32'h13);
      end
      // both no-op forms with random don't-care bits
      set_acc(1'b0, 40'h1234567890);
      wr(ADDR_STATUS, 32'h5a);
      for (int i = 0; i < 6; i++) begin
         r = 4'($urandom());
         if (r == 4'h9) r = 4'h8;
         run(i[0] ? {8'h00, 16'($urandom())} : {4'hf, r, 16'($urandom())});
      end
      rd(ADDR_STATUS, 32'h5a, 32'h3ff);
      rd_acc(1'b0, 40'h1234567890);
      // normalize left, right, and the cases that cannot be normalized
      set_acc(1'b0, 40'h0000001000);
      wr(ADDR_STATUS, 32'h0);
      run(24'hce6003);
      rd(wa(3), 32'hffee, 32'hffff);
      rd_acc(1'b0, 40'h0040000000);
      rd(ADDR_STATUS, 32'h40, 32'hc3);
      set_acc(1'b1, 40'h1200000000);
      wr(ADDR_STATUS, 32'h0a);
      run(24'hcee005);
      rd(wa(5), 32'h0006, 32'hffff);
      rd_acc(1'b1, 40'h0048000000);
      rd(ADDR_STATUS, 32'h08, 32'hca);
      for (int i = 0; i < 3; i++) begin
         set_acc(1'b0, unnorm[i]);
         wr(wa(6), 32'h1234);
         wr(ADDR_STATUS, 32'h40);
         run(24'hce6006);
         rd(wa(6), 32'h0, 32'hffff);
         rd_acc(1'b0, unnorm[i]);
         rd(ADDR_STATUS, 32'h80, 32'hc0);
      end
      // pop to file register, low and top of the 32k word range
      mem_i.mem[16'h1004 >> 1] = 16'ha401;
      mem_i.mem[16'h1002 >> 1] = 16'h7e3c;
      wr(wa(15), 32'h1006);
      wr(ADDR_STATUS, 32'h5a);
      run(24'hf91230);
      rd(wa(15), 32'h1004, 32'hffff);
      check("file word", {16'h0, mem_i.mem[16'h1230 >> 1]}, 32'ha401);
      run(24'hf9fffe);
      check("top file word", {16'h0, mem_i.mem[16'hfffe >> 1]}, 32'h7e3c);
      rd(ADDR_STATUS, 32'h5a, 32'h3ff);
      // pop to working register, direct and indirect destination
      mem_i.mem[16'h1006 >> 1] = 16'hc45a;
      wr(wa(15), 32'h1008);
      run(24'h78024f);
      rd(wa(4), 32'hc45a, 32'hffff);
      rd(wa(15), 32'h1006, 32'hffff);
      wr(wa(10), 32'h0e04);
      run(24'h780d4f);
      check("indirect word", {16'h0, mem_i.mem[16'h0e04 >> 1]}, 32'ha401);
      rd(wa(10), 32'h0e04, 32'hffff);
      rd(wa(15), 32'h1004, 32'hffff);
      rd(ADDR_STATUS, 32'h5a, 32'h3ff);
      // unknown encoding: illegal bit set, flags kept, pc still steps
      run(24'h100000);
      rd(ADDR_STATUS, 32'h15a, 32'h3ff);
      // unaligned working register offset is unmapped
      rd(8'h7d, 32'h0, 32'hffffffff, 1'b1);
      end_sim;
   end
endmodule
